//--- rtl/dac_status_flag_bank.sv
// Purpose: read-only status and sticky flag registers of a stereo DAC
// Assumes: register port with one-cycle rd/wr strobes on clk_i;
//          status levels from other clocks or analog detectors; overflow pulses on clk_i
// Notes:   read data is registered, valid one cycle after the strobe
//
// Behaviour
// - power status D7 shows left DAC powered
// - power status D5 shows left headphone driver
// - power status D4 shows left class-D driver
// - power status D3 shows right DAC powered
// - power status D1 shows right headphone driver
// - power status D0 shows right class-D driver
// - gain status D4 set when left gain settled
// - gain status D0 set when right gain settled
// - overflow D7 latches left DAC overflow
// - overflow D6 latches right DAC overflow
// - overflow D5 latches barrel shifter overflow
// - sticky flags clear when their register read
// - event D7 latches left driver short
// - event D6 latches right driver short
// - event D5 latches headset button press
// - event D4 latches headset insert or remove
// - event D3 latches left power above threshold
// - event D2 latches right power above threshold
// - live register mirrors current short, button, headset and threshold levels
`timescale 1ns/1ps
`default_nettype none
`include "dac_flag_cfg.svh"
module dac_status_flag_bank (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_rd_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            reg_rvalid_o,
	// power states, asynchronous levels
	input  wire logic       dac_left_up_i,
	input  wire logic       left_headphone_driver_up_i,
	input  wire logic       class_d_left_up_i,
	input  wire logic       dac_right_up_i,
	input  wire logic       right_headphone_driver_up_i,
	input  wire logic       class_d_right_up_i,
	// gain settled, asynchronous levels
	input  wire logic       gain_left_settled_i,
	input  wire logic       gain_right_settled_i,
	// overflow pulses, same clock
	input  wire logic       ovf_left_i,
	input  wire logic       ovf_right_i,
	input  wire logic       ovf_shifter_i,
	// detector levels, asynchronous
	input  wire logic       short_left_i,
	input  wire logic       short_right_i,
	input  wire logic       button_pressed_i,
	input  wire logic       headset_present_i,
	input  wire logic       drc_left_above_i,
	input  wire logic       drc_right_above_i
);
	localparam int NSYNC = 14;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [NSYNC-1:0] raw_lvl;
	logic [NSYNC-1:0] sync_lvl;

	assign raw_lvl = {dac_left_up_i, left_headphone_driver_up_i,
		class_d_left_up_i, dac_right_up_i,
		right_headphone_driver_up_i, class_d_right_up_i,
		gain_left_settled_i, gain_right_settled_i,
		short_left_i, short_right_i, button_pressed_i,
		headset_present_i, drc_left_above_i, drc_right_above_i};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			pin_sync u_sync (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.async_i (raw_lvl[gi]),
				.sync_o  (sync_lvl[gi])
			);
		end
	endgenerate

	logic s_dac_l, s_hp_l, s_cd_l, s_dac_r, s_hp_r, s_cd_r;
	logic s_gain_l, s_gain_r;
	logic s_short_l, s_short_r, s_button, s_headset, s_drc_l, s_drc_r;

	assign {s_dac_l, s_hp_l, s_cd_l, s_dac_r, s_hp_r, s_cd_r,
		s_gain_l, s_gain_r, s_short_l, s_short_r, s_button,
		s_headset, s_drc_l, s_drc_r} = sync_lvl;

	// ****************************************
	// edge detection of synchronised levels
	// ****************************************
	logic prev_short_l;
	logic prev_short_r;
	logic prev_button;
	logic prev_headset;
	logic prev_drc_l;
	logic prev_drc_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_short_l <= 1'b0;
			prev_short_r <= 1'b0;
			prev_button  <= 1'b0;
			prev_headset <= 1'b0;
			prev_drc_l   <= 1'b0;
			prev_drc_r   <= 1'b0;
		end else begin
			prev_short_l <= s_short_l;
			prev_short_r <= s_short_r;
			prev_button  <= s_button;
			prev_headset <= s_headset;
			prev_drc_l   <= s_drc_l;
			prev_drc_r   <= s_drc_r;
		end
	end

	// short and threshold flags latch while the condition stands
	logic [7:0] evt_set;
	always_comb begin
		evt_set = `RST_FLAG_BYTE;
		evt_set[`BIT_EVT_SHORT_L] = s_short_l;
		evt_set[`BIT_EVT_SHORT_R] = s_short_r;
		evt_set[`BIT_EVT_BUTTON]  = s_button && !prev_button;
		evt_set[`BIT_EVT_HEADSET] = s_headset != prev_headset;
		evt_set[`BIT_EVT_DRC_L]   = s_drc_l;
		evt_set[`BIT_EVT_DRC_R]   = s_drc_r;
	end

	logic [7:0] ovf_set;
	always_comb begin
		ovf_set = `RST_FLAG_BYTE;
		ovf_set[`BIT_OVF_L]     = ovf_left_i;
		ovf_set[`BIT_OVF_R]     = ovf_right_i;
		ovf_set[`BIT_OVF_SHIFT] = ovf_shifter_i;
	end

	// ****************************************
	// access decode
	// ****************************************
	dac_flag_pkg::acc_kind_t acc;
	always_comb begin
		if (reg_rd_i)
			acc = dac_flag_pkg::ACC_READ;
		else if (reg_wr_i)
			acc = dac_flag_pkg::ACC_WRITE;
		else
			acc = dac_flag_pkg::ACC_IDLE;
	end

	logic rd_ovf;
	logic rd_evt;
	assign rd_ovf = (acc == dac_flag_pkg::ACC_READ)
		&& (reg_addr_i == `OFS_OVERFLOW);
	assign rd_evt = (acc == dac_flag_pkg::ACC_READ)
		&& (reg_addr_i == `OFS_EVENT_STICKY);

	// ****************************************
	// sticky flags
	// ****************************************
	logic [7:0] ovf_flags;
	logic [7:0] evt_flags;

	generate
		for (gi = 0; gi < 8; gi++) begin : g_sticky
			sticky_flag u_ovf (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.set_i  (ovf_set[gi]),
				.clr_i  (rd_ovf),
				.flag_o (ovf_flags[gi])
			);
			sticky_flag u_evt (
				.clk_i  (clk_i),
				.rst_i  (rst_i),
				.set_i  (evt_set[gi]),
				.clr_i  (rd_evt),
				.flag_o (evt_flags[gi])
			);
		end
	endgenerate

	// ****************************************
	// writable reserved bits
	// ****************************************
	dac_flag_pkg::reg_byte_t pwr_rsvd;
	dac_flag_pkg::reg_byte_t gain_rsvd;
	dac_flag_pkg::reg_byte_t rsvd_a [4];
	dac_flag_pkg::reg_byte_t rsvd_b;

	// software keeps zero in power D6/D2 and gain D7-D5/D3-D1; stored as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_rsvd  <= `RST_RSVD_BYTE;
			gain_rsvd <= `RST_RSVD_BYTE;
			rsvd_b    <= `RST_RSVD_BYTE;
			for (int i = 0; i < 4; i++)
				rsvd_a[i] <= `RST_RSVD_BYTE;
		end else if (acc == dac_flag_pkg::ACC_WRITE) begin
			if (reg_addr_i == `OFS_POWER_STATE) begin
				pwr_rsvd[`BIT_PWR_RSVD_HI] <= reg_wdata_i[`BIT_PWR_RSVD_HI];
				pwr_rsvd[`BIT_PWR_RSVD_LO] <= reg_wdata_i[`BIT_PWR_RSVD_LO];
			end
			if (reg_addr_i == `OFS_GAIN_SETTLED)
				gain_rsvd[7:1] <= reg_wdata_i[7:1];
			if (reg_addr_i == `OFS_RSVD_B)
				rsvd_b <= reg_wdata_i;
			if (reg_addr_i >= `OFS_RSVD_A_FIRST
				&& reg_addr_i <= `OFS_RSVD_A_LAST)
				rsvd_a[reg_addr_i[1:0]] <= reg_wdata_i;
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	dac_flag_pkg::reg_byte_t pwr_view;
	dac_flag_pkg::reg_byte_t gain_view;
	dac_flag_pkg::reg_byte_t live_view;
	dac_flag_pkg::reg_byte_t next_rdata;

	always_comb begin
		pwr_view = `RST_FLAG_BYTE;
		pwr_view[`BIT_PWR_DAC_L]   = s_dac_l;
		pwr_view[`BIT_PWR_RSVD_HI] = pwr_rsvd[`BIT_PWR_RSVD_HI];
		pwr_view[`BIT_PWR_HP_L]    = s_hp_l;
		pwr_view[`BIT_PWR_CLSD_L]  = s_cd_l;
		pwr_view[`BIT_PWR_DAC_R]   = s_dac_r;
		pwr_view[`BIT_PWR_RSVD_LO] = pwr_rsvd[`BIT_PWR_RSVD_LO];
		pwr_view[`BIT_PWR_HP_R]    = s_hp_r;
		pwr_view[`BIT_PWR_CLSD_R]  = s_cd_r;
		gain_view = {gain_rsvd[7:5], 1'b0, gain_rsvd[3:1], 1'b0};
		gain_view[`BIT_GAIN_L] = s_gain_l;
		gain_view[`BIT_GAIN_R] = s_gain_r;
		live_view = `RST_FLAG_BYTE;
		live_view[`BIT_EVT_SHORT_L] = s_short_l;
		live_view[`BIT_EVT_SHORT_R] = s_short_r;
		live_view[`BIT_EVT_BUTTON]  = s_button;
		live_view[`BIT_EVT_HEADSET] = s_headset;
		live_view[`BIT_EVT_DRC_L]   = s_drc_l;
		live_view[`BIT_EVT_DRC_R]   = s_drc_r;
		case (reg_addr_i)
			`OFS_POWER_STATE:  next_rdata = pwr_view;
			`OFS_GAIN_SETTLED: next_rdata = gain_view;
			`OFS_OVERFLOW:     next_rdata = {ovf_flags[7:5], 5'h00};
			`OFS_EVENT_STICKY: next_rdata = {evt_flags[7:2], 2'h0};
			`OFS_RSVD_B:       next_rdata = rsvd_b;
			`OFS_EVENT_LIVE:   next_rdata = live_view;
			default: begin
				if (reg_addr_i >= `OFS_RSVD_A_FIRST
					&& reg_addr_i <= `OFS_RSVD_A_LAST)
					next_rdata = rsvd_a[reg_addr_i[1:0]];
				else
					next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= acc == dac_flag_pkg::ACC_READ;
			if (acc == dac_flag_pkg::ACC_READ)
				reg_rdata_o <= next_rdata;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence read_evt_s;
		reg_rd_i && reg_addr_i == `OFS_EVENT_STICKY;
	endsequence

	sequence quiet_evt_s;
		!evt_set[`BIT_EVT_SHORT_L] && !evt_set[`BIT_EVT_SHORT_R];
	endsequence

	sequence headset_edge_s;
		s_headset != prev_headset;
	endsequence

	a_read_latency: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i |=> reg_rvalid_o)
		else $error("read data not valid one cycle after strobe");
	a_evt_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		read_evt_s ##0 quiet_evt_s |=> !evt_flags[`BIT_EVT_SHORT_L]
		&& !evt_flags[`BIT_EVT_SHORT_R])
		else $error("short flags not cleared by read");
	a_short_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(s_short_l) |=> evt_flags[`BIT_EVT_SHORT_L])
		else $error("left short not latched");
	a_ovf_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_left_i |=> ovf_flags[`BIT_OVF_L])
		else $error("left overflow not latched");
	a_ovf_shift: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_shifter_i ##1 (reg_rd_i && reg_addr_i == `OFS_OVERFLOW)
		|=> reg_rdata_o[`BIT_OVF_SHIFT])
		else $error("shifter overflow not reported");
	a_live_short: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == `OFS_EVENT_LIVE
		|=> reg_rdata_o[`BIT_EVT_SHORT_R] == $past(s_short_r))
		else $error("live short flag mismatch");
	a_power_read: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == `OFS_POWER_STATE
		|=> reg_rdata_o[`BIT_PWR_DAC_L] == $past(s_dac_l))
		else $error("left DAC power bit mismatch");
	a_gain_read: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == `OFS_GAIN_SETTLED
		|=> reg_rdata_o[`BIT_GAIN_R] == $past(s_gain_r))
		else $error("right gain bit mismatch");
	a_button_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(s_button) |=> evt_flags[`BIT_EVT_BUTTON])
		else $error("button press not latched");
	a_headset_edge: assert property (@(posedge clk_i) disable iff (rst_i)
		headset_edge_s |=> evt_flags[`BIT_EVT_HEADSET])
		else $error("headset edge not latched");
	a_short_right: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(s_short_r) |=> evt_flags[`BIT_EVT_SHORT_R])
		else $error("right short not latched");
	a_drc_left: assert property (@(posedge clk_i) disable iff (rst_i)
		s_drc_l |=> evt_flags[`BIT_EVT_DRC_L])
		else $error("left threshold crossing not latched");
	a_drc_right: assert property (@(posedge clk_i) disable iff (rst_i)
		s_drc_r |=> evt_flags[`BIT_EVT_DRC_R])
		else $error("right threshold crossing not latched");
	a_ovf_right: assert property (@(posedge clk_i) disable iff (rst_i)
		ovf_right_i |=> ovf_flags[`BIT_OVF_R])
		else $error("right overflow not latched");
	a_live_left: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == `OFS_EVENT_LIVE
		|=> reg_rdata_o[`BIT_EVT_SHORT_L] == $past(s_short_l))
		else $error("live left short flag mismatch");
	a_clsd_read: assert property (@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == `OFS_POWER_STATE
		|=> reg_rdata_o[`BIT_PWR_CLSD_R] == $past(s_cd_r))
		else $error("right class-D power bit mismatch");
endmodule
`default_nettype wire

//--- rtl/dac_flag_cfg.svh
// Purpose: offsets, field positions and reset values of the flag bank
// Assumes: 8-bit registers on the device's internal register port
// Notes:   definitions only
`ifndef DAC_FLAG_CFG_SVH
`define DAC_FLAG_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_POWER_STATE    8'h25
`define OFS_GAIN_SETTLED   8'h26
`define OFS_OVERFLOW       8'h27
`define OFS_RSVD_A_FIRST   8'h28
`define OFS_RSVD_A_LAST    8'h2B
`define OFS_EVENT_STICKY   8'h2C
`define OFS_RSVD_B         8'h2D
`define OFS_EVENT_LIVE     8'h2E

// ****************************************
// field positions
// ****************************************
`define BIT_PWR_DAC_L      7
`define BIT_PWR_RSVD_HI    6
`define BIT_PWR_HP_L       5
`define BIT_PWR_CLSD_L     4
`define BIT_PWR_DAC_R      3
`define BIT_PWR_RSVD_LO    2
`define BIT_PWR_HP_R       1
`define BIT_PWR_CLSD_R     0
`define BIT_GAIN_L         4
`define BIT_GAIN_R         0
`define BIT_OVF_L          7
`define BIT_OVF_R          6
`define BIT_OVF_SHIFT      5
`define BIT_EVT_SHORT_L    7
`define BIT_EVT_SHORT_R    6
`define BIT_EVT_BUTTON     5
`define BIT_EVT_HEADSET    4
`define BIT_EVT_DRC_L      3
`define BIT_EVT_DRC_R      2

// ****************************************
// reset values
// ****************************************
`define RST_FLAG_BYTE      8'h00
`define RST_RSVD_BYTE      8'h00

`endif

//--- rtl/dac_flag_pkg.sv
// Purpose: types shared by the flag bank
// Assumes: nothing
// Notes:   constants live in dac_flag_cfg.svh
`default_nettype none
package dac_flag_pkg;
	typedef logic [7:0] reg_byte_t;

	typedef enum logic [1:0] {
		ACC_IDLE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b10
	} acc_kind_t;
endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: clk_i free running
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// level
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta   <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule
`default_nettype wire

//--- rtl/sticky_flag.sv
// Purpose: one clear-on-read sticky flag
// Assumes: set and clear from the clk_i domain
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flag_o <= 1'b0;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clr_i)
			flag_o <= 1'b0;
	end

	a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
		set_i |=> flag_o)
		else $error("sticky flag lost a same-cycle set");
	a_clear_read: assert property (@(posedge clk_i) disable iff (rst_i)
		clr_i && !set_i |=> !flag_o)
		else $error("sticky flag not cleared by read");
endmodule
`default_nettype wire

//--- verification/dac_status_flag_bank_test.sv
// Purpose: self-checking bench for the DAC status and flag bank
// Assumes: one-cycle read strobe, registered read data, 2-cycle syncs
// Notes:   inputs change at the falling edge, outputs seen mid-cycle
`timescale 1ns/1ps
`default_nettype none
`include "dac_flag_cfg.svh"
module dac_status_flag_bank_test;
	logic        clk_i;
	logic        rst_i;
	logic [7:0]  reg_addr_i;
	logic        reg_rd_i;
	logic        reg_wr_i;
	logic [7:0]  reg_wdata_i;
	logic [7:0]  reg_rdata_o;
	logic        reg_rvalid_o;
	logic [5:0]  pwr;
	logic [1:0]  gain;
	logic [2:0]  ovf;
	logic [5:0]  det;
	logic [7:0]  exp_v;
	logic [31:0] r;
	int          err_count;
	int          compares;
	int          cycles;

	dac_status_flag_bank u_dut (
		.clk_i                       (clk_i),
		.rst_i                       (rst_i),
		.reg_addr_i                  (reg_addr_i),
		.reg_rd_i                    (reg_rd_i),
		.reg_wr_i                    (reg_wr_i),
		.reg_wdata_i                 (reg_wdata_i),
		.reg_rdata_o                 (reg_rdata_o),
		.reg_rvalid_o                (reg_rvalid_o),
		.dac_left_up_i               (pwr[5]),
		.left_headphone_driver_up_i  (pwr[4]),
		.class_d_left_up_i           (pwr[3]),
		.dac_right_up_i              (pwr[2]),
		.right_headphone_driver_up_i (pwr[1]),
		.class_d_right_up_i          (pwr[0]),
		.gain_left_settled_i         (gain[1]),
		.gain_right_settled_i        (gain[0]),
		.ovf_left_i                  (ovf[2]),
		.ovf_right_i                 (ovf[1]),
		.ovf_shifter_i               (ovf[0]),
		.short_left_i                (det[5]),
		.short_right_i               (det[4]),
		.button_pressed_i            (det[3]),
		.headset_present_i           (det[2]),
		.drc_left_above_i            (det[1]),
		.drc_right_above_i           (det[0])
	);

	// ****************************************
	// clock and timeout
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] pwr_exp(input logic [5:0] p);
		return {p[5], 1'b0, p[4], p[3], p[2], 1'b0, p[1], p[0]};
	endfunction

	task automatic check8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask

	task automatic pause(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// entered at a falling edge; result seen half a cycle after the next rising edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string what);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		check8("rvalid", 8'h01, {7'h00, reg_rvalid_o});
		check8(what, e, reg_rdata_o);
		@(negedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
		@(negedge clk_i);
	endtask

	task automatic summarize();
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		err_count = 0;
		compares = 0;
		cycles = 0;
		rst_i = 1'b1;
		reg_addr_i = 8'h00;
		reg_rd_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_wdata_i = 8'h00;
		pwr = 6'h00;
		gain = 2'h0;
		ovf = 3'h0;
		det = 6'h00;
		void'($urandom(32'h6E868348));
		pause(5);
		rst_i = 1'b0;
		rd(`OFS_OVERFLOW, 8'h00, "ovf reset");
		rd(`OFS_EVENT_STICKY, 8'h00, "event reset");
		wr(`OFS_POWER_STATE, 8'hBB);
		for (int i = 0; i < 8; i++) begin
			r = (i == 0) ? 32'hFF : $urandom;
			pwr = r[5:0];
			gain = r[7:6];
			pause(4);
			rd(`OFS_POWER_STATE, pwr_exp(pwr), "power");
			rd(`OFS_GAIN_SETTLED, {3'h0, gain[1], 3'h0, gain[0]}, "gain");
		end
		for (int i = 0; i < 5; i++) begin
			r = $urandom;
			exp_v = {(i == 0) ? 3'h7 : r[2:0], 5'h00};
			ovf = exp_v[7:5];
			pause(1);
			ovf = 3'h0;
			rd(`OFS_OVERFLOW, exp_v, "overflow");
			rd(`OFS_OVERFLOW, 8'h00, "overflow cleared");
		end
		// trigger in the very cycle of the clearing read
		reg_addr_i = `OFS_OVERFLOW;
		reg_rd_i = 1'b1;
		ovf = 3'h4;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		ovf = 3'h0;
		check8("overflow race", 8'h00, reg_rdata_o);
		pause(1);
		rd(`OFS_OVERFLOW, 8'h80, "overflow kept");
		for (int i = 0; i < 8; i++) begin
			r = (i == 0) ? 32'h3F : $urandom;
			det = {r[0], r[1], det[3] ^ r[2], det[2] ^ r[3], r[4], r[5]};
			exp_v = {det[5:4], r[2] & det[3], r[3], det[1:0], 2'h0};
			pause(5);
			rd(`OFS_EVENT_STICKY, exp_v, "event");
			rd(`OFS_EVENT_LIVE, {det, 2'h0}, "live");
			det[5:4] = 2'h0;
			det[1:0] = 2'h0;
			pause(5);
			rd(`OFS_EVENT_STICKY, exp_v & 8'hCC, "event relatch");
			rd(`OFS_EVENT_STICKY, 8'h00, "event cleared");
		end
		wr(`OFS_RSVD_A_FIRST, 8'h00);
		rd(`OFS_RSVD_A_FIRST, 8'h00, "reserved");
		rd(`OFS_RSVD_B, 8'h00, "reserved b");
		rd(8'h2F, 8'h00, "unmapped");
		rd(8'h40, 8'h00, "unmapped");
		summarize();
	end
endmodule
`default_nettype wire
